// >>> rtl/board_glue.sv
// Purpose: ram bank steering, cpu memory mapper, boot memory map, port decode,
//          interrupt and bus-request priority chains
// Assumes: all inputs but the asynchronous rst_b_i synchronous to clk_i; strobes active high
// Notes: every output is registered, so selects lag the bus by one clock

module board_glue #(
  parameter logic [15:0] EPROM_BYTES = 16'h4000
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // cpu bus
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_data_i,
  input wire logic cpu_mreq_i,
  input wire logic cpu_iorq_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_m1_i,
  // on-board dma, owning the bus while bus_ack_i is high
  input wire logic bus_ack_i,
  input wire logic [15:0] dma_addr_i,
  input wire logic dma_mreq_i,
  input wire logic dma_rd_i,
  input wire logic dma_wr_i,
  input wire logic dma_bao_i,
  // straps
  input wire logic [7:0] boot_select_switch_bank_i,
  // interrupt chain, ordered dma, serial, parallel, timer
  input wire logic [3:0] dev_ieo_i,
  output logic [3:0] dev_iei_o,
  output logic ext_iei_o,
  output logic bus_grant_priority_out_o,
  // ram and boot memories
  output logic [16:0] ram_addr_o,
  output logic ram_rd_o,
  output logic ram_wr_o,
  output logic rom_sel_o,
  output logic eprom_sel_o,
  // port selects
  output logic serial_sel_o,
  output logic parallel_sel_o,
  output logic timer_sel_o,
  output logic floppy_sel_o,
  output logic floppy_ctrl_sel_o,
  output logic bus_data_sel_o,
  output logic dma_ctrl_sel_o,
  output logic ext_io_sel_o,
  // dma device routing: 0 floppy, 1 bus port
  output logic dma_to_bus_port_o,
  output logic boot_mapped_o
);

  // ---- decode helpers ----

  function automatic logic port_is(input logic [15:0] addr,
                                   input logic [6:0] port);
    port_is = (addr[6:0] == port);
  endfunction

  function automatic logic group_is(input logic [15:0] addr,
                                    input logic [6:0] base);
    group_is = ((addr[6:0] & board_map_pkg::PORT_GROUP_MASK) == base);
  endfunction

  // ---- bus cycle qualifiers ----

  logic io_cycle;
  logic io_write;
  logic cpu_mem;

  // an i/o request together with m1 is an interrupt acknowledge, not a port cycle
  assign io_cycle = cpu_iorq_i & ~cpu_m1_i & (cpu_rd_i | cpu_wr_i) & ~bus_ack_i;
  assign io_write = io_cycle & cpu_wr_i;
  assign cpu_mem = cpu_mreq_i & (cpu_rd_i | cpu_wr_i) & ~bus_ack_i;

  // ---- write-only registers ----

  logic [7:0] dma_bank;
  logic [7:0] map_select;
  logic bank_write;
  logic map_write;

  // bit 7 of the port is not decoded, so 94 and 97 alias these two registers
  assign bank_write = io_write & port_is(cpu_addr_i, board_map_pkg::PORT_DMA_BANK);
  assign map_write = io_write & port_is(cpu_addr_i, board_map_pkg::PORT_MAP_SELECT);

  // no read path: software must keep its own copy of both registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_bank <= board_map_pkg::DMA_BANK_RESET;
    end else if (bank_write) begin
      dma_bank <= cpu_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      map_select <= board_map_pkg::MAP_SELECT_RESET;
    end else if (map_write) begin
      map_select <= cpu_data_i;
    end
  end

  logic src_bank;
  logic dst_bank;
  logic map_bank;
  logic map_overlay;

  // only these bits and the device bit steer anything; the rest are stored and ignored
  assign src_bank = dma_bank[board_map_pkg::DMA_SRC_BANK_BIT];
  assign dst_bank = dma_bank[board_map_pkg::DMA_DST_BANK_BIT];
  assign map_bank = map_select[board_map_pkg::MAP_BANK_BIT];
  assign map_overlay = map_select[board_map_pkg::MAP_OVERLAY_BIT];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_to_bus_port_o <= 1'b0;
    end else begin
      dma_to_bus_port_o <= dma_bank[board_map_pkg::DMA_DEVICE_BIT];
    end
  end

  // ---- boot memory mapping ----

  board_map_pkg::boot_map_t boot_state;
  board_map_pkg::boot_map_t next_boot_state;
  logic dma_port_touched;
  logic eprom_strap;

  assign dma_port_touched = io_cycle & port_is(cpu_addr_i, board_map_pkg::PORT_DMA_CTRL);
  assign eprom_strap = boot_select_switch_bank_i[board_map_pkg::BOOT_SWITCH_BIT];

  // the strap is taken on the first clock after reset release, not by the reset
  always_comb begin
    next_boot_state = boot_state;
    case (boot_state)
      board_map_pkg::BOOT_PENDING: begin
        if (dma_port_touched) begin
          next_boot_state = board_map_pkg::BOOT_RAM_ONLY;
        end else if (eprom_strap) begin
          next_boot_state = board_map_pkg::BOOT_FROM_EPROM;
        end else begin
          next_boot_state = board_map_pkg::BOOT_FROM_ROM;
        end
      end
      board_map_pkg::BOOT_FROM_ROM: begin
        if (dma_port_touched) begin
          next_boot_state = board_map_pkg::BOOT_RAM_ONLY;
        end
      end
      board_map_pkg::BOOT_FROM_EPROM: begin
        if (dma_port_touched) begin
          next_boot_state = board_map_pkg::BOOT_RAM_ONLY;
        end
      end
      default: begin
        next_boot_state = board_map_pkg::BOOT_RAM_ONLY;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_state <= board_map_pkg::BOOT_PENDING;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  logic rom_mapped;
  logic eprom_mapped;

  // in the pending cycle the strap is read live so a very early fetch still lands
  assign rom_mapped = (boot_state == board_map_pkg::BOOT_FROM_ROM) ||
                      ((boot_state == board_map_pkg::BOOT_PENDING) && !eprom_strap);
  assign eprom_mapped = (boot_state == board_map_pkg::BOOT_FROM_EPROM) ||
                        ((boot_state == board_map_pkg::BOOT_PENDING) && eprom_strap);

  logic rom_read;
  logic eprom_read;

  // only reads are claimed; a write to the boot range falls through to ram
  assign rom_read = rom_mapped & cpu_mem & cpu_rd_i &
                    (cpu_addr_i < board_map_pkg::BOOT_ROM_BYTES);
  assign eprom_read = eprom_mapped & cpu_mem & cpu_rd_i &
                      (cpu_addr_i < EPROM_BYTES);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rom_sel_o <= 1'b0;
      eprom_sel_o <= 1'b0;
      boot_mapped_o <= 1'b1;
    end else begin
      rom_sel_o <= rom_read;
      eprom_sel_o <= eprom_read;
      boot_mapped_o <= (next_boot_state != board_map_pkg::BOOT_RAM_ONLY);
    end
  end

  // ---- cpu address mapping ----

  logic [1:0] cpu_seg;
  logic cpu_bank;
  logic [1:0] cpu_phys_seg;

  assign cpu_seg = cpu_addr_i[15:14];

  always_comb begin
    cpu_bank = map_bank;
    cpu_phys_seg = cpu_seg;
    if (cpu_seg == board_map_pkg::SEG_COMMON) begin
      cpu_bank = board_map_pkg::COMMON_BANK;
    end else if (map_overlay && cpu_seg == board_map_pkg::SEG_OVERLAY) begin
      cpu_bank = board_map_pkg::OVERLAY_BANK;
      cpu_phys_seg = board_map_pkg::OVERLAY_PHYS_SEG;
    end
  end

  // ---- dma address mapping ----

  logic dma_mem;
  logic dma_bank_sel;

  // a dma read fetches from the source, a write lands in the destination;
  // equal fields make i/o transfers use one bank either way
  assign dma_mem = bus_ack_i & dma_mreq_i & (dma_rd_i | dma_wr_i);
  assign dma_bank_sel = dma_rd_i ? src_bank : dst_bank;

  // ---- ram port ----

  // the dma path never reads map_select, so remapping cannot disturb a transfer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_addr_o <= 17'h00000;
      ram_rd_o <= 1'b0;
      ram_wr_o <= 1'b0;
    end else if (dma_mem) begin
      ram_addr_o <= {dma_bank_sel, dma_addr_i};
      ram_rd_o <= dma_rd_i;
      ram_wr_o <= dma_wr_i;
    end else begin
      ram_addr_o <= {cpu_bank, cpu_phys_seg, cpu_addr_i[13:0]};
      ram_rd_o <= cpu_mem & cpu_rd_i & ~rom_read & ~eprom_read;
      ram_wr_o <= cpu_mem & cpu_wr_i;
    end
  end

  // ---- port selects ----

  logic ext_range;

  assign ext_range = (cpu_addr_i[6:0] >= board_map_pkg::PORT_EXT_LO) &&
                     (cpu_addr_i[6:0] <= board_map_pkg::PORT_EXT_HI);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_sel_o <= 1'b0;
      parallel_sel_o <= 1'b0;
      timer_sel_o <= 1'b0;
      floppy_sel_o <= 1'b0;
    end else begin
      serial_sel_o <= io_cycle & group_is(cpu_addr_i, board_map_pkg::PORT_SERIAL_LO);
      parallel_sel_o <= io_cycle & group_is(cpu_addr_i, board_map_pkg::PORT_PARALLEL_LO);
      timer_sel_o <= io_cycle & group_is(cpu_addr_i, board_map_pkg::PORT_TIMER_LO);
      floppy_sel_o <= io_cycle & group_is(cpu_addr_i, board_map_pkg::PORT_FLOPPY_LO);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      floppy_ctrl_sel_o <= 1'b0;
      bus_data_sel_o <= 1'b0;
      dma_ctrl_sel_o <= 1'b0;
      ext_io_sel_o <= 1'b0;
    end else begin
      floppy_ctrl_sel_o <= io_cycle & port_is(cpu_addr_i, board_map_pkg::PORT_FLOPPY_CTRL);
      bus_data_sel_o <= io_cycle & port_is(cpu_addr_i, board_map_pkg::PORT_BUS_DATA);
      dma_ctrl_sel_o <= dma_port_touched;
      // the upper port space is handed out whole; no on-board device answers there
      ext_io_sel_o <= io_cycle & ext_range;
    end
  end

  // ---- priority chains ----

  logic [3:0] chain_iei;
  logic chain_end;

  irq_lookahead_chain #(
    .N(board_map_pkg::IRQ_DEVICES)
  ) u_irq_chain (
    .chain_top_i(1'b1),
    .dev_ieo_i(dev_ieo_i),
    .dev_iei_o(chain_iei),
    .chain_end_o(chain_end)
  );

  // a registered chain adds one clock of settle; slow cpu cycles hide it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dev_iei_o <= 4'h0;
      ext_iei_o <= 1'b0;
    end else begin
      dev_iei_o <= chain_iei;
      ext_iei_o <= chain_end;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_grant_priority_out_o <= 1'b0;
    end else begin
      bus_grant_priority_out_o <= dma_bao_i;
    end
  end

endmodule

// >>> common/board_map_pkg.sv
// Purpose: shared constants and types for the board memory map and port decode
// Assumes: eight-bit cpu with a separate i/o space, one clock domain
// Notes: port numbers are the low seven address bits; bit 7 is not decoded
package board_map_pkg;

  // i/o ports
  localparam logic [6:0] PORT_DMA_BANK = 7'h14;
  localparam logic [6:0] PORT_FLOPPY_CTRL = 7'h16;
  localparam logic [6:0] PORT_MAP_SELECT = 7'h17;
  localparam logic [6:0] PORT_BUS_DATA = 7'h19;
  localparam logic [6:0] PORT_DMA_CTRL = 7'h1a;
  localparam logic [6:0] PORT_SERIAL_LO = 7'h00;
  localparam logic [6:0] PORT_PARALLEL_LO = 7'h04;
  localparam logic [6:0] PORT_TIMER_LO = 7'h08;
  localparam logic [6:0] PORT_FLOPPY_LO = 7'h10;
  localparam logic [6:0] PORT_GROUP_MASK = 7'h7c;
  localparam logic [6:0] PORT_EXT_LO = 7'h20;
  localparam logic [6:0] PORT_EXT_HI = 7'h7f;

  // dma bank and device select fields
  localparam int DMA_DEVICE_BIT = 1;
  localparam int DMA_SRC_BANK_BIT = 4;
  localparam int DMA_DST_BANK_BIT = 6;
  localparam logic [7:0] DMA_BANK_RESET = 8'h00;

  // cpu memory map select fields
  localparam int MAP_BANK_BIT = 0;
  localparam int MAP_OVERLAY_BIT = 4;
  localparam logic [7:0] MAP_SELECT_RESET = 8'h00;

  // logical and physical segments
  localparam logic [1:0] SEG_OVERLAY = 2'h2;
  localparam logic [1:0] SEG_COMMON = 2'h3;
  localparam logic COMMON_BANK = 1'b0;
  localparam logic OVERLAY_BANK = 1'b1;
  localparam logic [1:0] OVERLAY_PHYS_SEG = 2'h3;

  // boot memory
  localparam logic [15:0] BOOT_ROM_BYTES = 16'h0020;
  localparam int BOOT_SWITCH_BIT = 3;

  // interrupt chain order, highest first
  localparam int IRQ_DMA = 0;
  localparam int IRQ_SERIAL = 1;
  localparam int IRQ_PARALLEL = 2;
  localparam int IRQ_TIMER = 3;
  localparam int IRQ_DEVICES = 4;

  typedef enum logic [1:0] {
    BOOT_PENDING = 2'b00,
    BOOT_FROM_ROM = 2'b01,
    BOOT_FROM_EPROM = 2'b10,
    BOOT_RAM_ONLY = 2'b11
  } boot_map_t;

endpackage

// >>> rtl/irq_lookahead_chain.sv
// Purpose: look-ahead enable chain for the interrupt priority daisy chain
// Assumes: position 0 is the highest priority; ieo high lets lower ones through
// Notes: purely combinational; the caller registers the enables
module irq_lookahead_chain #(
  parameter int N = 4
) (
  input wire logic chain_top_i,
  input wire logic [N-1:0] dev_ieo_i,
  output logic [N-1:0] dev_iei_o,
  output logic chain_end_o
);

  logic [N:0] enable;

  assign enable[0] = chain_top_i;

  // each enable is the and of every higher device, not a ripple through them
  for (genvar k = 0; k < N; k++) begin : g_stage
    assign enable[k+1] = enable[0] & (&dev_ieo_i[k:0]);
    assign dev_iei_o[k] = enable[k];
  end

  assign chain_end_o = enable[N];

endmodule

// >>> sim/board_glue_props.sv
// Purpose: port-level checks on board_glue
// Assumes: one clock, asynchronous active-low reset
// Notes: register contents are not visible here, the bench checks them
module board_glue_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_mreq_i,
  input wire logic cpu_iorq_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_m1_i,
  input wire logic bus_ack_i,
  input wire logic [15:0] dma_addr_i,
  input wire logic dma_mreq_i,
  input wire logic dma_rd_i,
  input wire logic dma_bao_i,
  input wire logic [3:0] dev_ieo_i,
  input wire logic [3:0] dev_iei_o,
  input wire logic ext_iei_o,
  input wire logic bus_grant_priority_out_o,
  input wire logic [16:0] ram_addr_o,
  input wire logic ram_rd_o,
  input wire logic ram_wr_o,
  input wire logic rom_sel_o,
  input wire logic ext_io_sel_o,
  input wire logic dma_ctrl_sel_o,
  input wire logic boot_mapped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic cmem;
  logic cio;
  assign cmem = !bus_ack_i && cpu_mreq_i && (cpu_rd_i || cpu_wr_i);
  assign cio = !bus_ack_i && cpu_iorq_i && !cpu_m1_i && (cpu_rd_i || cpu_wr_i);
  chk_common_area: assert property (
    cmem && cpu_addr_i[15:14] == 2'h3 |=> ram_addr_o[16:14] == 3'h3) else $error("common area left bank 0");
  chk_dma_port_unmap: assert property (
    cio && cpu_addr_i[6:0] == 7'h1a |=> dma_ctrl_sel_o && !boot_mapped_o) else $error("dma port cycle");
  chk_boot_stays_off: assert property (
    !boot_mapped_o |=> !boot_mapped_o) else $error("boot map came back");
  chk_ext_port_sel: assert property (
    cio && cpu_addr_i[6:5] != 2'h0 |=> ext_io_sel_o) else $error("external port not selected");
  chk_int_ack_quiet: assert property (
    cpu_iorq_i && cpu_m1_i && !bus_ack_i |=> !dma_ctrl_sel_o && !ext_io_sel_o) else $error("int ack selected");
  chk_chain_end: assert property (
    1'b1 |=> ext_iei_o == &$past(dev_ieo_i)) else $error("chain end wrong");
  chk_irq_order: assert property (
    1'b1 |=> dev_iei_o == {&$past(dev_ieo_i[2:0]), &$past(dev_ieo_i[1:0]), $past(dev_ieo_i[0]), 1'b1})
    else $error("chain order wrong");
  chk_grant_copy: assert property (
    1'b1 |=> bus_grant_priority_out_o == $past(dma_bao_i)) else $error("grant out wrong");
  chk_dma_addr: assert property (
    bus_ack_i && dma_mreq_i && dma_rd_i |=> ram_rd_o && ram_addr_o[15:0] == $past(dma_addr_i))
    else $error("dma address wrong");
  chk_boot_write_ram: assert property (
    cmem && cpu_wr_i && boot_mapped_o && cpu_addr_i < 16'h0020 |=> ram_wr_o && !rom_sel_o)
    else $error("boot write missed ram");
  cover property (cmem && boot_mapped_o && cpu_rd_i);
  cover property (cio && cpu_addr_i[6:0] == 7'h17);
  cover property (bus_ack_i && dma_mreq_i);
endmodule

bind board_glue board_glue_props u_props (.*);

// >>> sim/ram_banks_model.sv
// Purpose: the two 64k ram banks behind the glue
// Assumes: registered selects, sampled on the falling edge where settled
// Notes: only which bytes were written is kept, data is not modelled
module ram_banks_model (
  input wire logic clk_i,
  input wire logic [16:0] ram_addr_i,
  input wire logic ram_wr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  bit written [bit [16:0]];
  always @(negedge clk_i) begin
    if (ram_wr_i === 1'b1) begin
      written[ram_addr_i] = 1'b1;
    end
  end
  function automatic bit was_written(input logic [16:0] a);
    return written.exists(a);
  endfunction
endmodule

// >>> sim/board_glue_tb.sv
// Purpose: directed bench for board_glue
// Assumes: inputs move on the falling edge, outputs read one clock later
// Notes: two resets cover both boot straps
module board_glue_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000, dma_addr_i = 16'h0000;
  logic [7:0] cpu_data_i = 8'h00, boot_select_switch_bank_i = 8'h00;
  logic cpu_mreq_i = 1'b0, cpu_iorq_i = 1'b0, cpu_rd_i = 1'b0, cpu_wr_i = 1'b0, cpu_m1_i = 1'b0;
  logic bus_ack_i = 1'b0, dma_mreq_i = 1'b0, dma_rd_i = 1'b0, dma_wr_i = 1'b0, dma_bao_i = 1'b0;
  logic [3:0] dev_ieo_i = 4'hf;
  logic [3:0] dev_iei_o;
  logic [16:0] ram_addr_o;
  logic ext_iei_o, bus_grant_priority_out_o, ram_rd_o, ram_wr_o, rom_sel_o, eprom_sel_o;
  logic serial_sel_o, parallel_sel_o, timer_sel_o, floppy_sel_o, floppy_ctrl_sel_o;
  logic bus_data_sel_o, dma_ctrl_sel_o, ext_io_sel_o, dma_to_bus_port_o, boot_mapped_o;
  logic [7:0] sel;
  logic [7:0] codes [4] = '{8'h01, 8'h10, 8'h11, 8'hee};
  logic [6:0] ports [10] = '{7'h00, 7'h03, 7'h07, 7'h0b, 7'h13, 7'h16, 7'h19, 7'h20, 7'h7f, 7'h14};
  logic [7:0] onehot [10] = '{8'h80, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h01, 8'h00};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  board_glue u_dut (.*);
  ram_banks_model u_ram (.clk_i(clk_i), .ram_addr_i(ram_addr_o), .ram_wr_i(ram_wr_o));
  assign sel = {serial_sel_o, parallel_sel_o, timer_sel_o, floppy_sel_o, floppy_ctrl_sel_o, bus_data_sel_o,
    dma_ctrl_sel_o, ext_io_sel_o};
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // holds the cycle for exactly one clock; the next call or idle replaces it
  task automatic cyc(input logic dma, input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
    {bus_ack_i, dma_mreq_i, dma_rd_i, dma_wr_i} = {dma, dma, dma & !wr, dma & wr};
    {cpu_iorq_i, cpu_mreq_i, cpu_rd_i, cpu_wr_i} = {!dma & io, !dma & !io, !dma & !wr, !dma & wr};
    {cpu_addr_i, dma_addr_i, cpu_data_i} = {a, a, d};
    @(negedge clk_i);
  endtask
  task automatic idle();
    {bus_ack_i, dma_mreq_i, dma_rd_i, dma_wr_i} = 4'h0;
    {cpu_iorq_i, cpu_mreq_i, cpu_rd_i, cpu_wr_i} = 4'h0;
    @(negedge clk_i);
  endtask
  // esel is {rom, eprom}
  task automatic mem(input logic dma, input logic wr, input logic [15:0] a, input logic [16:0] ea,
    input logic [1:0] esel);
    cyc(dma, 1'b0, wr, a, 8'h00);
    check("ram_addr_o", ram_addr_o, ea);
    check("rd_wr_rom_eprom", {ram_rd_o, ram_wr_o, rom_sel_o, eprom_sel_o}, {!wr && esel == 2'b00, wr, esel});
  endtask
  function automatic logic [16:0] map_of(input logic [7:0] code, input logic [15:0] a);
    if (a[15:14] == 2'h3) return {1'b0, a};
    if (code[4] && a[15:14] == 2'h2) return {3'b111, a[13:0]};
    return {code[0], a};
  endfunction
  initial begin
    repeat (2) @(negedge clk_i);
    check("boot_mapped_o", boot_mapped_o, 1'b1);
    rst_b_i = 1'b1;
    idle();
    mem(1'b0, 1'b0, 16'h0000, 17'h00000, 2'b10);
    mem(1'b0, 1'b0, 16'h001f, 17'h0001f, 2'b10);
    mem(1'b0, 1'b0, 16'h0020, 17'h00020, 2'b00);
    mem(1'b0, 1'b1, 16'h0010, 17'h00010, 2'b00);
    mem(1'b0, 1'b0, 16'h4000, 17'h04000, 2'b00);
    cpu_m1_i = 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 16'h001a, 8'h00);
    check("int_ack_sel", {sel, boot_mapped_o}, 9'h001);
    cpu_m1_i = 1'b0;
    foreach (ports[i]) begin
      cyc(1'b0, 1'b1, 1'b0, {9'h000, ports[i]}, 8'h00);
      check("port_sel", sel, onehot[i]);
    end
    foreach (codes[i]) begin
      cyc(1'b0, 1'b1, 1'b1, (i == 1) ? 16'h0097 : 16'h0017, codes[i]);
      for (int s = 0; s < 4; s++) begin
        mem(1'b0, 1'b0, {s[1:0], 14'h0123}, map_of(codes[i], {s[1:0], 14'h0123}), 2'b00);
      end
    end
    cyc(1'b0, 1'b1, 1'b0, 16'h001a, 8'h00);
    check("unmap", {sel, boot_mapped_o}, 9'h004);
    mem(1'b0, 1'b0, 16'h0000, 17'h00000, 2'b00);
    cyc(1'b0, 1'b1, 1'b1, 16'h0014, 8'h12);
    // one dma cycle moves a single byte, as a force-ready byte move must
    mem(1'b1, 1'b0, 16'h1234, 17'h11234, 2'b00);
    check("dma_to_bus_port_o", dma_to_bus_port_o, 1'b1);
    cyc(1'b0, 1'b1, 1'b1, 16'h0017, 8'h11);
    mem(1'b1, 1'b1, 16'hffff, 17'h0ffff, 2'b00);
    // i/o transfer: source and destination bank set alike
    cyc(1'b0, 1'b1, 1'b1, 16'h0014, 8'h50);
    mem(1'b1, 1'b1, 16'h0005, 17'h10005, 2'b00);
    mem(1'b1, 1'b0, 16'h0005, 17'h10005, 2'b00);
    check("dma_to_bus_port_o", dma_to_bus_port_o, 1'b0);
    check("ram_written", {u_ram.was_written(17'h00010), u_ram.was_written(17'h10005)}, 2'b11);
    idle();
    for (int v = 0; v < 16; v++) begin
      dev_ieo_i = v[3:0];
      dma_bao_i = v[0];
      @(negedge clk_i);
      check("irq_chain", {ext_iei_o, dev_iei_o}, {&v[3:0], &v[2:0], &v[1:0], v[0], 1'b1});
      check("grant_out", bus_grant_priority_out_o, v[0]);
    end
    rst_b_i = 1'b0;
    boot_select_switch_bank_i = 8'h08;
    repeat (2) idle();
    rst_b_i = 1'b1;
    idle();
    mem(1'b0, 1'b0, 16'h3fff, 17'h03fff, 2'b01);
    mem(1'b0, 1'b0, 16'h4000, 17'h04000, 2'b00);
    mem(1'b1, 1'b0, 16'h0200, 17'h00200, 2'b00);
    mem(1'b0, 1'b1, 16'h0100, 17'h00100, 2'b00);
    cyc(1'b0, 1'b1, 1'b1, 16'h001a, 8'h00);
    check("boot_mapped_o", boot_mapped_o, 1'b0);
    mem(1'b0, 1'b0, 16'h0100, 17'h00100, 2'b00);
    idle();
    tally_and_finish();
  end
endmodule
